//--- design/prdc_regs.vh
// Purpose: constants of the prescaled reload down-counter (offsets, fields, resets).
// Assumes: APB with 32-bit data; each register takes one aligned word at index*4.
// Notes: register data sit in the low byte; upper bits read as zero.
`ifndef PRDC_REGS_VH
`define PRDC_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PRDC_IDX_CONTROL 6'h00
`define PRDC_IDX_STATUS 6'h01
`define PRDC_IDX_MASK 6'h02
`define PRDC_IDX_TMODE 6'h2a
`define PRDC_IDX_PRESCALE 6'h2b
`define PRDC_IDX_RELOAD_HI 6'h2c
`define PRDC_IDX_RELOAD_LO 6'h2d
`define PRDC_IDX_COUNT_HI 6'h2e
`define PRDC_IDX_COUNT_LO 6'h2f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRDC_MODE_AUTO_START 7
`define PRDC_MODE_GATE_HI 6
`define PRDC_MODE_GATE_LO 5
`define PRDC_MODE_AUTO_RELOAD 4
`define PRDC_MODE_PRESC_HI 3
`define PRDC_CTRL_START 0
`define PRDC_CTRL_STOP 1
`define PRDC_CTRL_EVEN 2
`define PRDC_CTRL_FIELD_ON 3
`define PRDC_CTRL_MULTI_RX 4
`define PRDC_STAT_EXPIRY 0
`define PRDC_STAT_START 1
`define PRDC_STAT_ACTIVE 7

// ----------------------------------------------------------------
// gate encodings and reset values
// ----------------------------------------------------------------
`define PRDC_GATE_NONE 2'h0
`define PRDC_GATE_SIGNAL 2'h1
`define PRDC_GATE_AUX 2'h2
`define PRDC_GATE_ADDR3 2'h3
`define PRDC_RST_BYTE 8'h00
`define PRDC_RST_COUNT 16'h0000
`define PRDC_RST_PRESC 13'h0000

`endif

//--- design/prdc_prescaler.v
// Purpose: divides reference clock edges into timer ticks.
// Assumes: ref_edge is a one-cycle pulse per reference clock rising edge.
// Notes: restart realigns the division so a fresh start gets a full first period.
`timescale 1ns/1ps
`include "prdc_regs.vh"

module prdc_prescaler (
    input wire pclk,
    input wire presetn,
    input wire restart,
    input wire ref_edge,
    input wire [11:0] prescale_value,
    input wire even_prescale_select,
    output reg tick
);

    reg [12:0] div_reg;
    wire [12:0] terminal;

    // counting edges 0..terminal spans terminal+1 reference periods
    assign terminal = {prescale_value, 1'b0} + {12'h000, even_prescale_select};

    // ----------------------------------------------------------------
    // edge divider
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= `PRDC_RST_PRESC;
            tick <= 1'b0;
        end else if (restart) begin
            div_reg <= `PRDC_RST_PRESC;
            tick <= 1'b0;
        end else if (ref_edge) begin
            if (div_reg == terminal) begin
                div_reg <= `PRDC_RST_PRESC;
                tick <= 1'b1;
            end else begin
                div_reg <= div_reg + 13'h0001;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // prdc_prescaler

//--- design/prdc_timer.v
// Purpose: 16-bit prescaled reload down-counter with APB registers and interrupt.
// Assumes: reference clock and gate pins are asynchronous to pclk; each reference
//          half period outlasts a pclk period, so every edge is seen after sync.
// Notes: protocol event inputs come from logic on pclk and are one-cycle pulses.
//        the two count bytes are read separately, so a read pair is not atomic.
//        gates are looked at only on ticks; a gate pulse between ticks is missed.
`timescale 1ns/1ps
`include "prdc_regs.vh"

module prdc_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ref_clk_pin,
    input wire signal_input_pin,
    input wire auxiliary_pin_one,
    input wire address_line_three,
    input wire tx_end_pulse,
    input wire field_on_pulse,
    input wire rx_stop_request,
    output reg timer_active_flag,
    output reg timer_expiry_flag,
    output reg timer_irq
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [3:0] pin_sync;
    reg ref_prev_reg;
    wire [3:0] pin_raw;
    wire ref_sync;
    wire ref_edge;

    assign pin_raw = {address_line_three, auxiliary_pin_one, signal_input_pin, ref_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            // each pin owns its two stages; only the second one is read
            reg stage1_reg;
            reg stage2_reg;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= pin_raw[gi];
                    stage2_reg <= stage1_reg;
                end
            end
            assign pin_sync[gi] = stage2_reg;
        end
    endgenerate

    assign ref_sync = pin_sync[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_sync;
        end
    end

    assign ref_edge = ref_sync & ~ref_prev_reg;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg [7:0] mode_reg;
    reg [7:0] prescale_reg;
    reg [7:0] reload_hi_reg;
    reg [7:0] reload_lo_reg;
    reg [7:0] control_reg;
    reg [1:0] status_reg;
    reg [1:0] mask_reg;
    reg [15:0] count_reg;
    reg running_reg;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [5:0] idx;
    wire aligned;
    wire access;
    wire wr_en;
    wire sw_start;
    wire sw_stop;
    wire wr_mode;
    wire wr_prescale;
    wire wr_reload_hi;
    wire wr_reload_lo;
    wire wr_control;
    wire wr_status;
    wire wr_mask;
    reg mapped;
    reg [7:0] rd_byte;

    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite & mapped;
    // count bytes get no strobe: a write there is accepted and dropped
    assign wr_mode = wr_en & (idx == `PRDC_IDX_TMODE);
    assign wr_prescale = wr_en & (idx == `PRDC_IDX_PRESCALE);
    assign wr_reload_hi = wr_en & (idx == `PRDC_IDX_RELOAD_HI);
    assign wr_reload_lo = wr_en & (idx == `PRDC_IDX_RELOAD_LO);
    assign wr_control = wr_en & (idx == `PRDC_IDX_CONTROL);
    assign wr_status = wr_en & (idx == `PRDC_IDX_STATUS);
    assign wr_mask = wr_en & (idx == `PRDC_IDX_MASK);
    assign sw_start = wr_control & pwdata[`PRDC_CTRL_START];
    assign sw_stop = wr_control & pwdata[`PRDC_CTRL_STOP];

    always @* begin
        mapped = aligned;
        rd_byte = 8'h00;
        case (idx)
            `PRDC_IDX_CONTROL: rd_byte = control_reg;
            `PRDC_IDX_STATUS: rd_byte = {running_reg, 5'h00, status_reg};
            `PRDC_IDX_MASK: rd_byte = {6'h00, mask_reg};
            `PRDC_IDX_TMODE: rd_byte = mode_reg;
            `PRDC_IDX_PRESCALE: rd_byte = prescale_reg;
            `PRDC_IDX_RELOAD_HI: rd_byte = reload_hi_reg;
            `PRDC_IDX_RELOAD_LO: rd_byte = reload_lo_reg;
            `PRDC_IDX_COUNT_HI: rd_byte = count_reg[15:8];
            `PRDC_IDX_COUNT_LO: rd_byte = count_reg[7:0];
            default: mapped = 1'b0;
        endcase
        if (!aligned) begin
            rd_byte = 8'h00;
        end
    end

    wire setup_phase;
    reg [31:0] rdata_next;

    assign setup_phase = psel & ~penable;

    // read data is captured in the setup cycle and then held until the next setup
    always @* begin
        rdata_next = prdata;
        if (setup_phase) begin
            rdata_next = pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        end
    end

    // one wait-free access: answer is ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `PRDC_RST_BYTE;
            prescale_reg <= `PRDC_RST_BYTE;
            reload_hi_reg <= `PRDC_RST_BYTE;
            reload_lo_reg <= `PRDC_RST_BYTE;
            control_reg <= `PRDC_RST_BYTE;
            mask_reg <= 2'h0;
        end else begin
            if (wr_mode) begin
                mode_reg <= pwdata[7:0];
            end
            if (wr_prescale) begin
                prescale_reg <= pwdata[7:0];
            end
            if (wr_reload_hi) begin
                reload_hi_reg <= pwdata[7:0];
            end
            if (wr_reload_lo) begin
                reload_lo_reg <= pwdata[7:0];
            end
            // start and stop are commands, they never stay set
            if (wr_control) begin
                control_reg <= {3'h0, pwdata[4:2], 2'h0};
            end
            if (wr_mask) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // mode fields
    // ----------------------------------------------------------------
    wire auto_start;
    wire [1:0] gate_source_select;
    wire auto_reload_enable;
    wire [11:0] prescale_value;
    wire even_prescale_select;
    wire initial_field_on;
    wire multi_frame_receive;
    wire [15:0] reload_value;

    assign auto_start = mode_reg[`PRDC_MODE_AUTO_START];
    assign gate_source_select = mode_reg[`PRDC_MODE_GATE_HI:`PRDC_MODE_GATE_LO];
    assign auto_reload_enable = mode_reg[`PRDC_MODE_AUTO_RELOAD];
    assign prescale_value = {mode_reg[`PRDC_MODE_PRESC_HI:0], prescale_reg};
    assign even_prescale_select = control_reg[`PRDC_CTRL_EVEN];
    assign initial_field_on = control_reg[`PRDC_CTRL_FIELD_ON];
    assign multi_frame_receive = control_reg[`PRDC_CTRL_MULTI_RX];
    assign reload_value = {reload_hi_reg, reload_lo_reg};

    // ----------------------------------------------------------------
    // start, stop and gate
    // ----------------------------------------------------------------
    wire proto_start;
    wire proto_stop;
    wire start_event;
    wire stop_event;
    reg gate_open;

    assign proto_start = auto_start & (tx_end_pulse | (initial_field_on & field_on_pulse));
    // receive side may end timing only when multi-frame receive is off
    assign proto_stop = auto_start & ~multi_frame_receive & rx_stop_request;
    assign start_event = sw_start | proto_start;
    assign stop_event = sw_stop | proto_stop;

    always @* begin
        case (gate_source_select)
            `PRDC_GATE_NONE: gate_open = 1'b1;
            `PRDC_GATE_SIGNAL: gate_open = pin_sync[1];
            `PRDC_GATE_AUX: gate_open = pin_sync[2];
            `PRDC_GATE_ADDR3: gate_open = pin_sync[3];
            default: gate_open = 1'b1;
        endcase
    end

    wire tick;

    prdc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .restart(start_event),
        .ref_edge(ref_edge),
        .prescale_value(prescale_value),
        .even_prescale_select(even_prescale_select),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // down counter
    // ----------------------------------------------------------------
    wire step;
    wire at_end;
    wire expiry;
    reg [15:0] count_next;
    reg running_next;

    assign step = running_reg & tick & gate_open;
    assign at_end = (count_reg == 16'h0001) | (count_reg == 16'h0000);
    // a stop in the ticking cycle leaves the count where it is, so no expiry either
    assign expiry = step & at_end & ~start_event & ~stop_event;

    always @* begin
        count_next = count_reg;
        running_next = running_reg;
        if (start_event) begin
            // start wins over a same-cycle stop so no start is lost
            count_next = reload_value;
            running_next = 1'b1;
        end else if (stop_event) begin
            running_next = 1'b0;
        end else if (step) begin
            if (at_end) begin
                if (auto_reload_enable) begin
                    count_next = reload_value;
                end else begin
                    count_next = 16'h0000;
                    running_next = 1'b0;
                end
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `PRDC_RST_COUNT;
            running_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            running_reg <= running_next;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ----------------------------------------------------------------
    wire [1:0] stat_set;
    wire [1:0] stat_clr;
    reg [1:0] status_next;

    assign stat_set = {start_event, expiry};
    assign stat_clr = wr_status ? pwdata[1:0] : 2'h0;

    // clear first, then set, so an event in the clearing cycle is kept
    always @* begin
        status_next = status_reg & ~stat_clr;
        status_next = status_next | stat_set;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= status_next;
        end
    end

    wire irq_next;

    assign irq_next = |(status_reg & mask_reg);

    // outputs register the current state, so they lag the status bits by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_active_flag <= 1'b0;
            timer_expiry_flag <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            timer_active_flag <= running_reg;
            timer_expiry_flag <= status_reg[`PRDC_STAT_EXPIRY];
            timer_irq <= irq_next;
        end
    end

endmodule // prdc_timer

//--- verif/prdc_timer_asserts.sv
// Purpose: port-level assertions for prdc_timer.
// Assumes: one clock; shadow copies follow completed APB writes.
// Notes: a tick on the same edge as a command is not modelled.
`timescale 1ns/1ps
`include "prdc_regs.vh"

module prdc_timer_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire tx_end_pulse,
    input wire rx_stop_request,
    input wire timer_active_flag,
    input wire timer_expiry_flag,
    input wire timer_irq
);
    // ---
    // shadow registers
    // ---
    reg [7:0] mode_reg;
    reg [7:0] ctrl_reg;
    reg mask_reg;
    wire done = psel && penable && pready && pwrite && !pslverr;
    wire ok = (paddr[1:0] == 2'h0) && ((paddr[7:2] < 6'h03) ||
        (paddr[7:2] >= `PRDC_IDX_TMODE && paddr[7:2] <= `PRDC_IDX_COUNT_LO));
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 8'h00;
            ctrl_reg <= 8'h00;
            mask_reg <= 1'b0;
        end else if (done) begin
            if (paddr[7:2] == `PRDC_IDX_TMODE)
                mode_reg <= pwdata[7:0];
            if (paddr[7:2] == `PRDC_IDX_CONTROL)
                ctrl_reg <= pwdata[7:0];
            if (paddr[7:2] == `PRDC_IDX_MASK)
                mask_reg <= pwdata[0];
        end
    end
    // ---
    // properties
    // ---
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence ctrl_wr_s;
        done && paddr[7:2] == `PRDC_IDX_CONTROL;
    endsequence
    sequence rx_hold_s;
        (mode_reg[7] && ctrl_reg[4] && rx_stop_request) ##1 timer_active_flag;
    endsequence
    chk_apb_answer: assert property (psel && !penable |=> pready && (pslverr == !$past(ok)))
        else $error("apb answer late or error flag wrong");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_sw_start: assert property (ctrl_wr_s ##0 pwdata[0] |-> ##2 timer_active_flag)
        else $error("software start did not run the timer");
    chk_stop_cmd: assert property (ctrl_wr_s ##0 (pwdata[1:0] == 2'h2) |-> ##2 !timer_active_flag)
        else $error("stop command did not halt the timer");
    chk_auto_start: assert property (mode_reg[7] && tx_end_pulse |-> ##2 timer_active_flag)
        else $error("transmit end did not start the timer");
    chk_rx_keep: assert property (rx_hold_s |=> timer_active_flag)
        else $error("receive stop halted a multi-frame timer");
    chk_expiry_stop: assert property ($rose(timer_expiry_flag) && !mode_reg[4] |-> !timer_active_flag)
        else $error("timer still running after expiry");
    chk_reload_run: assert property ($rose(timer_expiry_flag) && mode_reg[4] |-> timer_active_flag)
        else $error("auto reload timer stopped at expiry");
    chk_irq_level: assert property (timer_expiry_flag && $past(mask_reg) |-> timer_irq)
        else $error("unmasked expiry without interrupt");
endmodule // prdc_timer_asserts

//--- verif/tb_prescaled_reload_downcounter.sv
// Purpose: self-checking bench for the prescaled reload down-counter.
// Assumes: the reference pin runs free at 13.56 MHz, unrelated to pclk.
// Notes: tick timing is judged in a window since the pin is synchronised.
`timescale 1ns/1ps
`include "prdc_regs.vh"

module tb_prescaled_reload_downcounter;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg ref_clk = 1'b0;
    reg [2:0] gate = 3'h0;
    reg [2:0] evt = 3'h0;
    reg [15:0] seed = 16'h0019;
    wire [31:0] prdata;
    wire pready, pslverr, act, expf, irq;
    logic [32:0] exp_q[$];
    logic [32:0] e_now;
    integer num_errors = 0;
    integer checks = 0;
    localparam logic [32:0] one = 33'h1;

    prdc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_clk_pin(ref_clk), .signal_input_pin(gate[0]),
        .auxiliary_pin_one(gate[1]), .address_line_three(gate[2]), .tx_end_pulse(evt[0]),
        .field_on_pulse(evt[1]), .rx_stop_request(evt[2]), .timer_active_flag(act),
        .timer_expiry_flag(expf), .timer_irq(irq));

    always #12.5 pclk = ~pclk;
    always #36.873 ref_clk = ~ref_clk;

    // ---
    // shared tasks
    // ---
    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input [7:0] a, input [31:0] d, input [32:0] e);
        integer n;
        n = 0;
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n = n + 1;
        end
        if (n >= 50)
            num_errors = num_errors + 1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input [5:0] i, input [7:0] d);
        xfer(1'b1, {i, 2'h0}, {24'h0, d}, 33'h0);
    endtask
    task automatic rd(input [5:0] i, input [7:0] d);
        xfer(1'b0, {i, 2'h0}, 32'h0, {25'h0, d});
    endtask
    task automatic pulse(input [2:0] p);
        @(posedge pclk);
        evt <= p;
        @(posedge pclk);
        evt <= 3'h0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic wexp(output integer c);
        c = 0;
        while (expf !== 1'b1 && c < 9000) begin
            @(posedge pclk);
            c = c + 1;
        end
    endtask
    // window allows for sync latency plus one reference period of phase
    task automatic timed(input [7:0] md, ps, ct, rl, input integer n, input logic m);
        integer c;
        real lo;
        wr(`PRDC_IDX_MASK, {7'h0, m});
        wr(`PRDC_IDX_TMODE, md);
        wr(`PRDC_IDX_PRESCALE, ps);
        wr(`PRDC_IDX_RELOAD_LO, rl);
        wr(`PRDC_IDX_STATUS, 8'h03);
        wr(`PRDC_IDX_CONTROL, ct | 8'h01);
        wexp(c);
        lo = (n - 1) * 73.746 / 25.0;
        check({32'h0, c >= lo && c <= lo + 7.0}, one);
        check({32'h0, irq}, {32'h0, m});
        rd(`PRDC_IDX_STATUS, 8'h03);
        rd(`PRDC_IDX_COUNT_LO, 8'h00);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            e_now = exp_q.pop_front();
            check({pslverr, pwrite ? 32'h0 : prdata}, pwrite ? {e_now[32], 32'h0} : e_now);
        end
    end

    initial begin
        repeat (30000) @(posedge pclk);
        num_errors = num_errors + 1;
        end_sim;
    end

    initial begin
        integer g;
        integer c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (g = `PRDC_IDX_TMODE; g <= `PRDC_IDX_RELOAD_LO; g = g + 1)
            rd(g[5:0], 8'h00);
        for (g = 0; g < 4; g = g + 1) begin
            seed = lfsr(seed);
            wr(`PRDC_IDX_TMODE, seed[7:0]);
            wr(`PRDC_IDX_PRESCALE, seed[15:8]);
            rd(`PRDC_IDX_TMODE, seed[7:0]);
            rd(`PRDC_IDX_PRESCALE, seed[15:8]);
        end
        xfer(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
        $display("test registers done");
        timed(8'h00, 8'h02, 8'h00, 8'h04, 20, 1'b1);
        timed(8'h00, 8'h02, 8'h04, 8'h04, 24, 1'b0);
        timed(8'h01, 8'h00, 8'h00, 8'h01, 513, 1'b1);
        wr(`PRDC_IDX_STATUS, 8'h03);
        repeat (2) @(posedge pclk);
        check({32'h0, irq}, 33'h0);
        wr(`PRDC_IDX_COUNT_HI, 8'h55);
        rd(`PRDC_IDX_COUNT_HI, 8'h00);
        $display("test timing done");
        for (g = 1; g < 4; g = g + 1) begin
            gate <= ~(3'h1 << (g - 1));
            wr(`PRDC_IDX_TMODE, {1'b0, g[1:0], 5'h0});
            wr(`PRDC_IDX_STATUS, 8'h03);
            wr(`PRDC_IDX_CONTROL, 8'h01);
            repeat (60) @(posedge pclk);
            check({32'h0, act}, one);
            rd(`PRDC_IDX_COUNT_LO, 8'h01);
            gate <= 3'h7;
            wexp(c);
            check({32'h0, c < 9000}, one);
        end
        $display("test gating done");
        wr(`PRDC_IDX_TMODE, 8'h10);
        wr(`PRDC_IDX_STATUS, 8'h03);
        wr(`PRDC_IDX_CONTROL, 8'h01);
        wexp(c);
        check({32'h0, c < 9000}, one);
        @(posedge pclk);
        check({32'h0, act}, one);
        wr(`PRDC_IDX_TMODE, 8'h0f);
        wr(`PRDC_IDX_PRESCALE, 8'hff);
        wr(`PRDC_IDX_RELOAD_HI, 8'h01);
        wr(`PRDC_IDX_RELOAD_LO, 8'h00);
        wr(`PRDC_IDX_CONTROL, 8'h01);
        rd(`PRDC_IDX_COUNT_HI, 8'h01);
        wr(`PRDC_IDX_RELOAD_HI, 8'h7f);
        rd(`PRDC_IDX_COUNT_HI, 8'h01);
        rd(`PRDC_IDX_RELOAD_HI, 8'h7f);
        wr(`PRDC_IDX_CONTROL, 8'h01);
        rd(`PRDC_IDX_COUNT_HI, 8'h7f);
        rd(`PRDC_IDX_COUNT_LO, 8'h00);
        $display("test reload done");
        wr(`PRDC_IDX_TMODE, 8'h8f);
        wr(`PRDC_IDX_CONTROL, 8'h0a);
        pulse(3'h2);
        check({32'h0, act}, one);
        wr(`PRDC_IDX_CONTROL, 8'h18);
        pulse(3'h4);
        check({32'h0, act}, one);
        wr(`PRDC_IDX_CONTROL, 8'h02);
        pulse(3'h1);
        check({32'h0, act}, one);
        pulse(3'h4);
        check({32'h0, act}, 33'h0);
        $display("test auto start done");
        end_sim;
    end
endmodule // tb_prescaled_reload_downcounter

bind prdc_timer prdc_timer_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .tx_end_pulse, .rx_stop_request, .timer_active_flag,
    .timer_expiry_flag, .timer_irq);
